// [verilog/eeps_sequencer.v]
// EEPROM program and erase sequencer with control and config registers.
`timescale 1ns/1ps
`include "eeps_defines.vh"
module eeps_sequencer #(
  parameter TBASE_DIV  = `EEPS_TBASE_CYC,
  parameter AUTO_TICKS = `EEPS_AUTO_TICKS,
  parameter DEPTH      = 512
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        ce,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  input  wire [7:0]  nv_config,
  output reg  [7:0]  rdata_q,
  output reg         pump_on_q,
  output reg         cycle_fail_q,
  output reg         busy_q
);
  // =============================================================
  // Decode
  wire       in_array = (addr >= `EEPS_ARRAY_BASE) && (addr <= `EEPS_ARRAY_LAST);
  wire [8:0] aidx     = addr[8:0];
  wire       hit_ctrl = (addr == `EEPS_CTRL_ADDR);
  wire       hit_acr  = (addr == `EEPS_ACR_ADDR);

  reg [7:0] ctrl_q;
  reg [7:0] acr_q;
  reg       acr_load_q;
  reg [8:0] lat_addr_q;
  reg [7:0] lat_data_q;
  reg       lat_valid_q;
  reg [7:0] tick_cnt_q;
  reg [7:0] mem_q [0:DEPTH-1];

  wire lat  = ctrl_q[`EEPS_B_LAT];
  wire pgm  = ctrl_q[`EEPS_B_PGM];
  wire off  = ctrl_q[`EEPS_B_OFF];
  wire [1:0] mode = {ctrl_q[`EEPS_B_RAS1], ctrl_q[`EEPS_B_RAS0]};
  wire secured = ~acr_q[4];
  wire tick;

  eeps_timebase #(.DIV(TBASE_DIV)) u_tb (
    .clock  (clock),
    .rst    (rst),
    .ce     (ce),
    .run    (pgm),
    .tick_q (tick)
  );

  // =============================================================
  // Protection of one array index under the current mode
  function allowed;
    input [8:0] idx;
    input [1:0] md;
    reg         prot;
    reg         sec_loc;
    begin
      prot    = acr_q[idx[8:7]];
      sec_loc = secured && (idx[8:4] == 5'h0f);
      allowed = !prot && !sec_loc &&
                !(secured && (md == `EEPS_MODE_BLOCK || md == `EEPS_MODE_BULK));
    end
  endfunction

  // Control write acceptance while latching.
  wire ctrl_ok  = !lat || lat_valid_q;
  wire auto_end = pgm && ctrl_q[`EEPS_B_AUTO] && tick &&
                  (tick_cnt_q == AUTO_TICKS[7:0] - 8'd1) ;
  wire do_apply;
  assign do_apply = pgm && ((wr && hit_ctrl && ctrl_ok && !wdata[`EEPS_B_PGM]) || auto_end);

  // =============================================================
  // Control register
  reg [7:0] ctrl_d;
  always @* begin
    ctrl_d = ctrl_q;
    if (wr && hit_ctrl && ctrl_ok) begin
      ctrl_d = wdata;
      ctrl_d[2] = 1'b0;
      if (wdata[`EEPS_B_PGM] && !(lat && lat_valid_q && wdata[`EEPS_B_LAT]))
        ctrl_d[`EEPS_B_PGM] = pgm;
      if (pgm && !wdata[`EEPS_B_LAT])
        ctrl_d[`EEPS_B_LAT] = 1'b1;
    end
    if (auto_end)
      ctrl_d[`EEPS_B_PGM] = 1'b0;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q     <= `EEPS_CTRL_RST;
      acr_q      <= 8'h00;
      acr_load_q <= 1'b1;
      tick_cnt_q <= 8'h00;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      if (acr_load_q) begin
        acr_q      <= nv_config;
        acr_load_q <= 1'b0;
      end
      if (!pgm)
        tick_cnt_q <= 8'h00;
      else if (tick)
        tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // =============================================================
  // Address and data latch
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lat_addr_q  <= 9'h000;
      lat_data_q  <= 8'h00;
      lat_valid_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl_d[`EEPS_B_LAT]) begin
        lat_valid_q <= 1'b0;
      end else if (lat && !pgm && wr && in_array) begin
        lat_addr_q  <= aidx;
        lat_data_q  <= wdata;
        lat_valid_q <= 1'b1;
      end else if (lat && !pgm && rd && in_array) begin
        lat_addr_q <= aidx;
      end
    end
  end

  // =============================================================
  // Sequence phase
  // The pump may only run in the pumping phase, which is reached solely from a
  // phase that holds a valid capture; the decay phase returns to idle once the latch bit is cleared.
  localparam [2:0] PH_IDLE   = 3'b000;
  localparam [2:0] PH_ARMED  = 3'b001;
  localparam [2:0] PH_LOADED = 3'b010;
  localparam [2:0] PH_PUMP   = 3'b011;
  localparam [2:0] PH_DECAY  = 3'b100;

  wire      capture = lat && !pgm && wr && in_array;
  reg [2:0] phase_q;
  reg [2:0] phase_d;

  always @* begin
    phase_d = phase_q;
    case (phase_q)
      PH_IDLE: begin
        if (ctrl_d[`EEPS_B_LAT])
          phase_d = PH_ARMED;
      end
      PH_ARMED: begin
        if (!ctrl_d[`EEPS_B_LAT])
          phase_d = PH_IDLE;
        else if (capture)
          phase_d = PH_LOADED;
      end
      PH_LOADED, PH_DECAY: begin
        if (!ctrl_d[`EEPS_B_LAT])
          phase_d = PH_IDLE;
        else if (ctrl_d[`EEPS_B_PGM])
          phase_d = PH_PUMP;
      end
      PH_PUMP: begin
        if (!ctrl_d[`EEPS_B_PGM])
          phase_d = PH_DECAY;
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end

  // =============================================================
  // Array storage, one generate entry per byte
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_mem
      localparam [31:0] ME_FULL = gi;
      wire [8:0] me = ME_FULL[8:0];
      wire hit = (mode == `EEPS_MODE_BULK) ||
                 (mode == `EEPS_MODE_BLOCK && me[8:7] == lat_addr_q[8:7]) ||
                 (me == lat_addr_q);
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          mem_q[gi] <= `EEPS_ARRAY_ERASED;
        end else if (ce && do_apply && !cycle_fail_q && hit && allowed(me, mode)) begin
          if (mode == `EEPS_MODE_PROG)
            mem_q[gi] <= mem_q[gi] & lat_data_q;
          else
            mem_q[gi] <= `EEPS_ARRAY_ERASED;
        end
      end
    end
  endgenerate

  // =============================================================
  // Read path and status
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q      <= 8'h00;
      pump_on_q    <= 1'b0;
      cycle_fail_q <= 1'b0;
      busy_q       <= 1'b0;
    end else if (ce) begin
      pump_on_q <= (phase_d == PH_PUMP);
      busy_q    <= ctrl_d[`EEPS_B_PGM];
      if (!pgm)
        cycle_fail_q <= 1'b0;
      else if (rd && in_array)
        cycle_fail_q <= 1'b1;
      if (rd) begin
        if (hit_ctrl)
          rdata_q <= ctrl_q;
        else if (hit_acr)
          rdata_q <= acr_q;
        else if (in_array && off)
          rdata_q <= 8'h00;
        else if (in_array && lat)
          rdata_q <= lat_data_q;
        else if (in_array)
          rdata_q <= mem_q[aidx];
        else
          rdata_q <= 8'h00;
      end
    end
  end
endmodule

// [verilog/eeps_defines.vh]
// Constants for the EEPROM program and erase sequencer.
`ifndef EEPS_DEFINES_VH
`define EEPS_DEFINES_VH

// =============================================================
// Register map
`define EEPS_ARRAY_BASE     16'h0600
`define EEPS_ARRAY_LAST     16'h07ff
`define EEPS_CTRL_ADDR      16'hff7e
`define EEPS_ACR_ADDR       16'hff7f
`define EEPS_NVR_ADDR       16'hff7c
`define EEPS_SEC_LO         16'h06f0
`define EEPS_SEC_HI         16'h06ff

// =============================================================
// Control register fields
`define EEPS_B_SPARE        7
`define EEPS_B_OFF          6
`define EEPS_B_RAS1         5
`define EEPS_B_RAS0         4
`define EEPS_B_LAT          3
`define EEPS_B_AUTO         1
`define EEPS_B_PGM          0
`define EEPS_CTRL_RST       8'h00
`define EEPS_NVR_DEFAULT    8'hf0
`define EEPS_ARRAY_ERASED   8'hff

// =============================================================
// Modes and timing
`define EEPS_MODE_PROG      2'b00
`define EEPS_MODE_BYTE      2'b01
`define EEPS_MODE_BLOCK     2'b10
`define EEPS_MODE_BULK      2'b11
`define EEPS_CLK_MHZ        250
`define EEPS_TBASE_NS       35000
`define EEPS_TBASE_CYC      ((`EEPS_TBASE_NS * `EEPS_CLK_MHZ) / 1000)
`define EEPS_AUTO_TICKS     8'd100

`endif

// [verilog/eeps_timebase.v]
// Tick generator that divides the clock to the 35 us timebase.
`timescale 1ns/1ps
`include "eeps_defines.vh"
module eeps_timebase #(
  parameter DIV = `EEPS_TBASE_CYC
) (
  input  wire clock,
  input  wire rst,
  input  wire ce,
  input  wire run,
  output reg  tick_q
);
  reg [23:0] cnt_q;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q  <= 24'h000000;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (!run) begin
        cnt_q <= 24'h000000;
      end else if (cnt_q == DIV[23:0] - 24'h000001) begin
        cnt_q  <= 24'h000000;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 24'h000001;
      end
    end
  end
endmodule

// [testbench/eeps_checker.sv]
// Checker for the sequencer's bus port and status outputs.
`timescale 1ns/1ps
`include "eeps_defines.vh"
module eeps_checker (
  input wire        clock,
  input wire        rst,
  input wire [15:0] addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  nv_config,
  input wire [7:0]  rdata_q,
  input wire        pump_on_q,
  input wire        cycle_fail_q,
  input wire        busy_q
);
  wire arr = addr >= `EEPS_ARRAY_BASE && addr <= `EEPS_ARRAY_LAST;
  wire cw  = wr && addr == `EEPS_CTRL_ADDR;
  wire ra  = rd && addr == `EEPS_ACR_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_pump_tracks_enable: assert property (pump_on_q == busy_q)
    else $error("pump off enable");
  a_enable_set_cause: assert property ($rose(busy_q) |-> $past(cw && wdata[0]))
    else $error("enable without write");
  a_enable_stays_off: assert property (!busy_q && !cw |=> !busy_q)
    else $error("enable rose alone");
  a_fail_from_read: assert property ($rose(cycle_fail_q) |-> $past(rd && arr && busy_q))
    else $error("fail without read");
  a_fail_idle_low: assert property (!busy_q [*2] |-> !cycle_fail_q)
    else $error("fail while idle");
  a_config_readback: assert property (ra && $stable(nv_config) |=> rdata_q == $past(nv_config))
    else $error("config read wrong");
  a_unmapped_zero: assert property (rd && !arr && addr[15:8] != 8'hff |=> rdata_q == 8'h00)
    else $error("unmapped not zero");
  a_read_data_holds: assert property (!rd |=> $stable(rdata_q))
    else $error("read data moved");
  c_enable: cover property ($rose(busy_q));
  c_auto_end: cover property ($fell(busy_q) && !$past(cw));
  c_fail: cover property ($rose(cycle_fail_q));
endmodule

bind eeps_sequencer eeps_checker chk_u (.*);

// [testbench/eeps_cpu.sv]
// Software model that drives the sequencer's register port.
`timescale 1ns/1ps
`include "eeps_defines.vh"
module eeps_cpu (
  input  wire        clock,
  output reg  [15:0] addr = 16'h0000,
  output reg  [7:0]  wdata = 8'h00,
  output reg         wr = 1'b0,
  output reg         rd = 1'b0,
  input  wire [7:0]  rdata_q
);
  // Address and data are inverted when released so stale values never match.
  task w(input [15:0] a, input [7:0] d);
    begin
      @(posedge clock) {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clock) {addr, wdata, wr} <= {~a, ~d, 1'b0};
      #1;
    end
  endtask
  task r(input [15:0] a, output [7:0] d);
    begin
      @(posedge clock) {addr, rd} <= {a, 1'b1};
      @(posedge clock) {addr, rd} <= {~a, 1'b0};
      #1 d = rdata_q;
    end
  endtask
  // Manual cycle: arm latch with mode, write target, enable, wait, release.
  task op(input [7:0] m, input [15:0] a, input [7:0] d);
    begin
      w(`EEPS_CTRL_ADDR, m | 8'h08);
      w(a, d);
      w(`EEPS_CTRL_ADDR, m | 8'h09);
      repeat (8) @(posedge clock);
      w(`EEPS_CTRL_ADDR, m | 8'h08);
      repeat (8) @(posedge clock);
      w(`EEPS_CTRL_ADDR, 8'h00);
    end
  endtask
endmodule

// [testbench/eeps_sequencer_tb.sv]
// Bench for the EEPROM program and erase sequencer.
`timescale 1ns/1ps
`include "eeps_defines.vh"
module eeps_sequencer_tb;
  localparam C = `EEPS_CTRL_ADDR;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  nvc = 8'hf0;
  reg  [7:0]  v;
  wire [15:0] addr;
  wire [7:0]  wdata, rdata_q;
  wire        wr, rd, pump_on_q, cycle_fail_q, busy_q;
  integer     n_errors = 0, checked = 0, i;
  always #2 clock = ~clock;
  eeps_cpu p (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q));
  eeps_sequencer #(.TBASE_DIV(4)) dut_u (.clock(clock), .rst(rst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .nv_config(nvc), .rdata_q(rdata_q),
    .pump_on_q(pump_on_q), .cycle_fail_q(cycle_fail_q), .busy_q(busy_q));
  task cmp(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rc(input [15:0] a, input [7:0] e);
    begin
      p.r(a, v);
      cmp(v, e);
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  task t_auto;
    begin
      p.w(C, 8'h0a);
      p.w(C, 8'h0b);
      rc(C, 8'h0a);
      p.w(16'h0800, 8'h00);
      p.w(C, 8'h0b);
      rc(C, 8'h0a);
      p.w(16'h0680, 8'h55);
      p.w(16'h0681, 8'ha5);
      rc(16'h0681, 8'ha5);
      p.w(C, 8'h0b);
      cmp({6'h0, pump_on_q, busy_q}, 8'h03);
      for (i = 0; i < 300 && v[0] !== 1'b0; i = i + 1) p.r(C, v);
      cmp(v, 8'h0a);
      cmp({6'h0, pump_on_q, busy_q}, 8'h00);
      p.w(C, 8'h00);
      rc(16'h0681, 8'ha5);
      rc(16'h0680, 8'hff);
    end
  endtask
  task t_manual;
    begin
      p.w(C, 8'h08);
      p.w(16'h0700, 8'h0f);
      p.w(C, 8'h09);
      p.w(C, 8'h01);
      rc(C, 8'h09);
      p.w(C, 8'h00);
      rc(C, 8'h08);
      p.w(C, 8'h00);
      rc(C, 8'h00);
      rc(16'h0700, 8'h0f);
    end
  endtask
  task t_erase;
    begin
      p.op(8'h10, 16'h0700, 8'h5a);
      rc(16'h0700, 8'hff);
      p.op(8'h00, 16'h0700, 8'h00);
      p.op(8'h00, 16'h0780, 8'h00);
      p.op(8'h20, 16'h0710, 8'h00);
      rc(16'h0700, 8'hff);
      rc(16'h0780, 8'h00);
      p.op(8'h30, 16'h0600, 8'h00);
      rc(16'h0780, 8'hff);
      p.w(16'h0700, 8'h00);
      rc(16'h0700, 8'hff);
    end
  endtask
  task t_fail;
    begin
      p.w(C, 8'h08);
      p.w(16'h0720, 8'h00);
      p.w(C, 8'h09);
      p.r(16'h0720, v);
      cmp({7'h0, cycle_fail_q}, 8'h01);
      p.w(C, 8'h08);
      p.w(C, 8'h00);
      rc(16'h0720, 8'hff);
    end
  endtask
  task t_misc;
    begin
      rc(`EEPS_ACR_ADDR, 8'hf0);
      p.w(C, 8'hc0);
      rc(C, 8'hc0);
      rc(16'h0700, 8'h00);
      p.w(C, 8'h00);
      rc(16'h1234, 8'h00);
      p.w(C, 8'h01);
      rc(C, 8'h00);
      @(posedge clock) {rst, nvc} <= {1'b1, 8'he1};
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rc(`EEPS_ACR_ADDR, 8'he1);
      p.op(8'h00, 16'h0600, 8'h00);
      rc(16'h0600, 8'hff);
      p.op(8'h00, 16'h06f0, 8'h00);
      rc(16'h06f0, 8'hff);
      p.op(8'h00, 16'h0700, 8'h00);
      p.op(8'h20, 16'h0700, 8'h00);
      rc(16'h0700, 8'h00);
      p.op(8'h10, 16'h0700, 8'h00);
      rc(16'h0700, 8'hff);
    end
  endtask
  initial begin
    #60000;
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_auto;
    t_manual;
    t_erase;
    t_fail;
    t_misc;
    give_verdict;
  end
endmodule
